// [led_sink_cfg.svh]
// constants for the led sink control registers: addresses, reset values,
// field positions and ramp step times
// assumes: included by bare name from the package, the control bank and the bench
`ifndef LED_SINK_CFG_SVH
`define LED_SINK_CFG_SVH

// ============================================================
// clock
`define MCLK_PERIOD_NS 100

// ============================================================
// register addresses
`define ADDR_GENERAL   8'h10
`define ADDR_PRIMARY   8'hA0
`define ADDR_SECONDARY 8'hB0

// ============================================================
// reset values
`define GENERAL_RESET  8'hC0
`define BRIGHT_RESET   8'hE0
`define GENERAL_ONES   2'h3
`define UNMAPPED_READ  8'h00

// ============================================================
// general control field positions
`define BIT_PRI_EN   0
`define BIT_SEC_EN   1
`define BIT_SHARED   2
`define BIT_RAMP_LO  3
`define BIT_RAMP_HI  4
`define BIT_BIAS     5
`define FIELD_MSB    5
`define CODE_MSB     4

// ============================================================
// ramp step times, per code step
`define STEP_FAST_NS   51000
`define STEP_SLOW1_MS  13
`define STEP_SLOW2_MS  26
`define STEP_SLOW3_MS  52
`define NS_PER_MS      1000000

// ============================================================
// ramp field codes, low bit first
`define RAMP_FAST   2'h0
`define RAMP_SLOW1  2'h1
`define RAMP_SLOW2  2'h2

`endif

// [led_sink_ctrl.sv]
// control register bank for a two-output white led driver: holds the
// general control and two brightness registers, decodes sink enables,
// ramps each sink code toward its brightness (both toward the primary one in shared mode) and maps it to a level
// assumes: a serial slave on mclk hands over whole register writes and
// reads as one-cycle strobes; the analog side acts on the outputs
`timescale 1ns/1ns

`include "led_sink_cfg.svh"

module led_sink_ctrl
    import led_sink_pkg::*;
#(
    parameter int STEP_SLOW1_CYC =
        `STEP_SLOW1_MS * (`NS_PER_MS / `MCLK_PERIOD_NS),
    parameter int STEP_SLOW2_CYC =
        `STEP_SLOW2_MS * (`NS_PER_MS / `MCLK_PERIOD_NS),
    parameter int STEP_SLOW3_CYC =
        `STEP_SLOW3_MS * (`NS_PER_MS / `MCLK_PERIOD_NS)
) (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   sys_rst,
    // register access from the serial slave
    input  wire logic   regWrite,
    input  wire logic   regRead,
    input  wire reg8_t  regAddr,
    input  wire reg8_t  regWdata,
    output reg8_t       regRdata,
    // sink control
    output logic        primarySinkEnable,
    output logic        secondarySinkEnable,
    output logic        feedbackMode,
    output logic        analogEnable,
    // sink current codes and levels
    output code_t       primaryCode,
    output code_t       secondaryCode,
    output level_t      primaryLevel,
    output level_t      secondaryLevel
);

    localparam int STEP_FAST_CYC =
        (`STEP_FAST_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
    // only the writable fields of the reset value are stored
    localparam reg8_t GENERAL_RST = `GENERAL_RESET;

    // ============================================================
    // address decode, shared by writes and reads
    function automatic reg_sel_t decodeAddr(input reg8_t addr);
        reg_sel_t s;
        s = SEL_NONE;
        case (addr)
            `ADDR_GENERAL:   s = SEL_GENERAL;
            `ADDR_PRIMARY:   s = SEL_PRIMARY;
            `ADDR_SECONDARY: s = SEL_SECONDARY;
            default:         s = SEL_NONE;
        endcase
        return s;
    endfunction

    function automatic step_cnt_t stepPeriod(input logic [1:0] rate);
        step_cnt_t p;
        p = 20'h00000;
        case (rate)
            `RAMP_FAST:  p = step_cnt_t'(STEP_FAST_CYC);
            `RAMP_SLOW1: p = step_cnt_t'(STEP_SLOW1_CYC);
            `RAMP_SLOW2: p = step_cnt_t'(STEP_SLOW2_CYC);
            default:     p = step_cnt_t'(STEP_SLOW3_CYC);
        endcase
        return p;
    endfunction

    // ============================================================
    // register file
    logic [`FIELD_MSB:0] generalControl;
    reg8_t               primaryBrightness;
    reg8_t               secondaryBrightness;
    reg8_t               next_generalFull;
    reg8_t               next_primaryBrightness;
    reg8_t               next_secondaryBrightness;
    reg8_t               next_regRdata;
    reg_sel_t            wrSel;
    reg_sel_t            rdSel;

    always_comb begin
        wrSel                    = decodeAddr(regAddr);
        rdSel                    = decodeAddr(regAddr);
        next_generalFull         = {`GENERAL_ONES, generalControl};
        next_primaryBrightness   = primaryBrightness;
        next_secondaryBrightness = secondaryBrightness;
        next_regRdata            = regRdata;
        // writes to unmapped addresses are dropped
        if (regWrite) begin
            case (wrSel)
                SEL_GENERAL:   next_generalFull = regWdata;
                SEL_PRIMARY:   next_primaryBrightness = regWdata;
                SEL_SECONDARY: next_secondaryBrightness = regWdata;
                default:       next_generalFull = next_generalFull;
            endcase
        end
        if (regRead) begin
            case (rdSel)
                // top two bits always read as one
                SEL_GENERAL:
                    next_regRdata = {`GENERAL_ONES, generalControl};
                // brightness reads return the stored byte
                SEL_PRIMARY:   next_regRdata = primaryBrightness;
                SEL_SECONDARY: next_regRdata = secondaryBrightness;
                default:       next_regRdata = `UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            generalControl      <= GENERAL_RST[`FIELD_MSB:0];
            primaryBrightness   <= `BRIGHT_RESET;
            secondaryBrightness <= `BRIGHT_RESET;
            regRdata            <= `UNMAPPED_READ;
        end else begin
            // writes to the top two bits are not kept
            generalControl      <= next_generalFull[`FIELD_MSB:0];
            primaryBrightness   <= next_primaryBrightness;
            secondaryBrightness <= next_secondaryBrightness;
            regRdata            <= next_regRdata;
        end
    end

    // ============================================================
    // mode decode
    logic priEn;
    logic secEn;
    logic shared;
    logic bias;
    logic next_primarySinkEnable;
    logic next_secondarySinkEnable;
    logic next_feedbackMode;
    logic next_analogEnable;

    assign priEn  = generalControl[`BIT_PRI_EN];
    assign secEn  = generalControl[`BIT_SEC_EN];
    assign shared = generalControl[`BIT_SHARED];
    assign bias   = generalControl[`BIT_BIAS];

    always_comb begin
        // primary follows its own enable in every mode
        next_primarySinkEnable = priEn;
        if (bias) begin
            // secondary pin becomes the feedback input
            // secondary enable ignored in bias mode
            next_secondarySinkEnable = 1'b0;
        end else if (shared) begin
            // shared mode keys both sinks off the primary bit
            // secondary bit cannot light the sink here
            next_secondarySinkEnable = priEn;
        end else begin
            next_secondarySinkEnable = secEn;
        end
        next_feedbackMode = bias;
        next_analogEnable = priEn | secEn | bias;
    end

    // decoded outputs move one edge after the register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            primarySinkEnable   <= 1'b0;
            secondarySinkEnable <= 1'b0;
            feedbackMode        <= 1'b0;
            analogEnable        <= 1'b0;
        end else begin
            primarySinkEnable   <= next_primarySinkEnable;
            secondarySinkEnable <= next_secondarySinkEnable;
            feedbackMode        <= next_feedbackMode;
            analogEnable        <= next_analogEnable;
        end
    end

    // ============================================================
    // ramp engines, one per sink
    code_t     target  [2];
    code_t     rampCur [2];
    code_t     lastTgt [2];
    step_cnt_t stepCnt [2];
    step_cnt_t period;

    // ramp rate field, low bit first
    assign period = stepPeriod({generalControl[`BIT_RAMP_LO],
                                generalControl[`BIT_RAMP_HI]});

    always_comb begin
        // only the low five bits reach the sinks
        target[0] = primaryBrightness[`CODE_MSB:0];
        // shared mode hands the primary code to both sinks
        target[1] = shared ? primaryBrightness[`CODE_MSB:0]
                           : secondaryBrightness[`CODE_MSB:0];
    end

    for (genvar i = 0; i < 2; i++) begin : gen_ramp
        code_t     next_cur;
        code_t     next_last;
        step_cnt_t next_cnt;
        code_t     stepped;

        always_comb begin
            stepped   = (target[i] > rampCur[i]) ? rampCur[i] + 5'h01
                                                 : rampCur[i] - 5'h01;
            next_cur  = rampCur[i];
            next_last = target[i];
            next_cnt  = 20'h00000;
            if (target[i] != lastTgt[i]) begin
                // first step is taken at once, so only
                // difference minus one steps cost a step time
                if (target[i] != rampCur[i])
                    next_cur = stepped;
            end else if (rampCur[i] != target[i]) begin
                // each later step waits one full step time
                if (stepCnt[i] >= period - 20'h00001) begin
                    next_cur = stepped;
                end else begin
                    next_cnt = stepCnt[i] + 20'h00001;
                end
            end
        end

        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                rampCur[i] <= 5'h00;
                lastTgt[i] <= 5'h00;
                stepCnt[i] <= 20'h00000;
            end else begin
                rampCur[i] <= next_cur;
                lastTgt[i] <= next_last;
                stepCnt[i] <= next_cnt;
            end
        end
    end

    assign primaryCode   = rampCur[0];
    assign secondaryCode = rampCur[1];

    // ============================================================
    // level table
    level_rom_if levelPort ();

    assign levelPort.addr[0] = rampCur[0];
    assign levelPort.addr[1] = rampCur[1];
    assign primaryLevel      = levelPort.data[0];
    assign secondaryLevel    = levelPort.data[1];

    // codes map through the fixed table
    level_rom u_level_rom (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .port    (levelPort.rom)
    );

    // ============================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_general_ones: assert property (
        regRead && regAddr == `ADDR_GENERAL |=> regRdata[7:6] == 2'h3)
        else $error("general control top bits not read as one");

    a_primary_follow: assert property (
        regWrite && regAddr == `ADDR_GENERAL
        |=> ##1 primarySinkEnable == $past(regWdata[0], 2))
        else $error("primary enable did not follow write");

    a_bias_secondary: assert property (
        bias |=> !secondarySinkEnable && feedbackMode)
        else $error("secondary sink on in bias mode");

    a_shared_on: assert property (
        !bias && shared && priEn |=> secondarySinkEnable && primarySinkEnable)
        else $error("shared mode did not enable both sinks");

    a_shared_off: assert property (
        !bias && shared && !priEn && secEn |=> !secondarySinkEnable)
        else $error("shared mode lit secondary without primary");

    a_indep_enable: assert property (
        !bias && !shared |=> secondarySinkEnable == $past(secEn))
        else $error("independent secondary enable wrong");

    a_analog_en: assert property (
        ##1 analogEnable == $past(priEn | secEn | bias))
        else $error("analog enable wrong");

    a_shared_target: assert property (
        shared |-> target[1] == primaryBrightness[`CODE_MSB:0])
        else $error("shared mode secondary target not primary code");

    a_ramp_first: assert property (
        target[0] != lastTgt[0] && target[0] != rampCur[0]
        |=> rampCur[0] != $past(rampCur[0]))
        else $error("first ramp step not immediate");

    a_ramp_spacing: assert property (
        target[0] == lastTgt[0] && rampCur[0] != target[0]
        && stepCnt[0] < period - 20'h00001
        |=> $stable(rampCur[0]))
        else $error("ramp stepped before its step time");

    a_read_bright: assert property (
        regRead && regAddr == `ADDR_PRIMARY
        |=> regRdata == $past(primaryBrightness))
        else $error("primary brightness read back wrong");

    a_reset_clear: assert property (
        $fell(sys_rst) |-> generalControl == GENERAL_RST[`FIELD_MSB:0]
        && primaryBrightness == `BRIGHT_RESET)
        else $error("registers not at reset values after reset");

    c_shared_mode: cover property (
        !bias && shared && priEn ##1 secondarySinkEnable);
    c_bias_mode: cover property (bias ##1 feedbackMode);
    c_ramp_done: cover property (
        rampCur[1] != target[1] ##[1:100] rampCur[1] == target[1]);
    c_read_general: cover property (
        regRead && regAddr == `ADDR_GENERAL);

endmodule

// [led_sink_host.sv]
// host-side model: issues whole register writes and reads as strobes
// assumes: the bank takes a strobe on the rising edge of mclk
`timescale 1ns/1ns

module led_sink_host
    import led_sink_pkg::*;
(
    // clock
    input  wire logic  mclk,
    // register access toward the bank
    output logic       regWrite,
    output logic       regRead,
    output reg8_t      regAddr,
    output reg8_t      regWdata,
    input  wire reg8_t regRdata
);
    // ============================================================
    // idle state
    initial begin
        regWrite = 1'h0;
        regRead  = 1'h0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // ============================================================
    // bus cycles, launched after a falling edge
    // released lines show inverted values so stale data is never reused
    // address then data
    task automatic write_reg(input reg8_t addr, input reg8_t data);
        @(negedge mclk);
        regAddr  = addr;
        regWdata = data;
        regWrite = 1'h1;
        @(negedge mclk);
        regWrite = 1'h0;
        regAddr  = ~addr;
        regWdata = ~data;
    endtask

    task automatic read_reg(input reg8_t addr, output reg8_t data);
        @(negedge mclk);
        regAddr = addr;
        regRead = 1'h1;
        @(negedge mclk);
        regRead = 1'h0;
        regAddr = ~addr;
        data    = regRdata;
    endtask
endmodule

// [led_sink_pkg.sv]
// types shared by the led sink control modules
// assumes: led_sink_cfg.svh sits in the same folder
`include "led_sink_cfg.svh"

package led_sink_pkg;

    typedef logic [7:0]  reg8_t;
    typedef logic [4:0]  code_t;
    // current in thousandths of a percent of full scale
    typedef logic [16:0] level_t;
    typedef logic [19:0] step_cnt_t;

    typedef enum {
        SEL_NONE,
        SEL_GENERAL,
        SEL_PRIMARY,
        SEL_SECONDARY
    } reg_sel_t;

endpackage

// [level_rom.sv]
// fixed table from 5-bit brightness code to current fraction of full scale
// assumes: addresses come from mclk logic; data appear one edge later
`timescale 1ns/1ns

module level_rom
    import led_sink_pkg::*;
(
    // clock
    input wire logic    mclk,
    input wire logic    sys_rst,
    // read ports
    level_rom_if.rom    port
);

    // ============================================================
    // table lookup
    function automatic level_t lookup(input code_t code);
        level_t v;
        v = 17'h00000;
        case (code)
            5'h00: v = 17'd0;
            5'h01: v = 17'd125;
            5'h02: v = 17'd625;
            5'h03: v = 17'd1000;
            5'h04: v = 17'd1125;
            5'h05: v = 17'd1313;
            5'h06: v = 17'd1688;
            5'h07: v = 17'd2063;
            5'h08: v = 17'd2438;
            5'h09: v = 17'd2813;
            5'h0A: v = 17'd3125;
            5'h0B: v = 17'd3750;
            5'h0C: v = 17'd4375;
            5'h0D: v = 17'd5250;
            5'h0E: v = 17'd6250;
            5'h0F: v = 17'd7500;
            5'h10: v = 17'd8750;
            5'h11: v = 17'd10000;
            5'h12: v = 17'd12500;
            5'h13: v = 17'd15000;
            5'h14: v = 17'd16875;
            5'h15: v = 17'd18750;
            5'h16: v = 17'd22500;
            5'h17: v = 17'd26250;
            5'h18: v = 17'd31250;
            5'h19: v = 17'd37500;
            5'h1A: v = 17'd43750;
            5'h1B: v = 17'd52500;
            5'h1C: v = 17'd61250;
            5'h1D: v = 17'd70000;
            5'h1E: v = 17'd87500;
            5'h1F: v = 17'd100000;
            default: v = 17'h00000;
        endcase
        return v;
    endfunction

    // ============================================================
    // registered read
    level_t next_data [2];

    always_comb begin
        next_data[0] = lookup(port.addr[0]);
        next_data[1] = lookup(port.addr[1]);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port.data[0] <= 17'h00000;
            port.data[1] <= 17'h00000;
        end else begin
            port.data[0] <= next_data[0];
            port.data[1] <= next_data[1];
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_table_ends: assert property (
        (port.addr[0] == 5'h00 |=> port.data[0] == 17'd0) and
        (port.addr[0] == 5'h1F |=> port.data[0] == 17'd100000))
        else $error("table end points wrong");
    a_table_mid: assert property (
        (port.addr[1] == 5'h01 |=> port.data[1] == 17'd125) and
        (port.addr[1] == 5'h10 |=> port.data[1] == 17'd8750) and
        (port.addr[1] == 5'h1E |=> port.data[1] == 17'd87500))
        else $error("table mid points wrong");

endmodule

// [level_rom_if.sv]
// two read ports between the control bank and the level table
// assumes: both ends run on mclk
`timescale 1ns/1ns

interface level_rom_if;
    import led_sink_pkg::*;

    code_t  addr [2];
    level_t data [2];

    modport rom  (input addr, output data);
    modport user (output addr, input data);
endinterface

// [test_led_sink_control_registers.sv]
// self-checking bench for the led sink control bank
// assumes: host model drives the strobes; slow ramp steps are shortened
`timescale 1ns/1ns

`include "led_sink_cfg.svh"

module test_led_sink_control_registers
    import led_sink_pkg::*;
;
    localparam int P1    = 20;
    localparam int P2    = 40;
    localparam int P3    = 80;
    localparam int PF    = 510;
    localparam int LIMIT = 20000;

    logic   mclk;
    logic   sys_rst;
    logic   regWrite;
    logic   regRead;
    reg8_t  regAddr;
    reg8_t  regWdata;
    reg8_t  regRdata;
    logic   primarySinkEnable;
    logic   secondarySinkEnable;
    logic   feedbackMode;
    logic   analogEnable;
    code_t  primaryCode;
    code_t  secondaryCode;
    level_t primaryLevel;
    level_t secondaryLevel;
    reg8_t  rd;
    logic   [3:0] expFlags;
    int     n_fail;
    int     num_checks;
    int     cyc;

    led_sink_ctrl #(.STEP_SLOW1_CYC(P1), .STEP_SLOW2_CYC(P2),
        .STEP_SLOW3_CYC(P3)) i_led_sink_ctrl (
        .mclk(mclk), .sys_rst(sys_rst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .primarySinkEnable(primarySinkEnable),
        .secondarySinkEnable(secondarySinkEnable),
        .feedbackMode(feedbackMode), .analogEnable(analogEnable),
        .primaryCode(primaryCode), .secondaryCode(secondaryCode),
        .primaryLevel(primaryLevel), .secondaryLevel(secondaryLevel));

    led_sink_host i_led_sink_host (
        .mclk(mclk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

    // ============================================================
    // clock, timeout and reporting
    initial begin
        mclk = 1'h0;
        forever #(`MCLK_PERIOD_NS / 2) mclk = ~mclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic note(input bit bad, input level_t got, input level_t exp);
        num_checks++;
        if (bad) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // ============================================================
    // compare tasks, one per kind of result
    task automatic check_reg(input reg8_t got, input reg8_t exp);
        note(got !== exp, level_t'(got), level_t'(exp));
    endtask

    task automatic check_flags(input logic [3:0] got, input logic [3:0] exp);
        note(got !== exp, level_t'(got), level_t'(exp));
    endtask

    task automatic check_code(input code_t got, input code_t exp);
        note(got !== exp, level_t'(got), level_t'(exp));
    endtask

    task automatic check_level(input level_t got, input level_t exp);
        note(got !== exp, got, exp);
    endtask

    task automatic read_check(input reg8_t addr, input reg8_t exp);
        i_led_sink_host.read_reg(addr, rd);
        check_reg(rd, exp);
    endtask

    // one write, then the step before the last, the last, and the level
    // a change of one code is not used: the first step lands at once
    task automatic ramp(input reg8_t addr, input reg8_t data, input int per,
                        input bit sec, input code_t from, input code_t tgt,
                        input level_t lvl);
        int d;
        d = (tgt > from) ? int'(tgt - from) : int'(from - tgt);
        i_led_sink_host.write_reg(addr, data);
        repeat ((d - 1) * per) @(posedge mclk);
        @(negedge mclk);
        check_code(sec ? secondaryCode : primaryCode,
                   (tgt > from) ? tgt - 5'h01 : tgt + 5'h01);
        @(negedge mclk);
        check_code(sec ? secondaryCode : primaryCode, tgt);
        @(negedge mclk);
        check_level(sec ? secondaryLevel : primaryLevel, lvl);
    endtask

    // ============================================================
    // main sequence
    initial begin
        n_fail     = 0;
        num_checks = 0;
        cyc        = 0;
        sys_rst    = 1'h1;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'h0;
        check_flags({primarySinkEnable, secondarySinkEnable, feedbackMode,
                     analogEnable}, 4'h0);
        check_level(primaryLevel, 17'h00000);
        read_check(`ADDR_GENERAL, 8'hC0);
        read_check(`ADDR_PRIMARY, 8'hE0);
        read_check(`ADDR_SECONDARY, 8'hE0);
        i_led_sink_host.write_reg(8'h20, 8'h55);
        read_check(8'h20, `UNMAPPED_READ);
        i_led_sink_host.write_reg(`ADDR_GENERAL, 8'h3F);
        read_check(`ADDR_GENERAL, 8'hFF);
        // enable decoding over every mode combination
        for (int i = 0; i < 16; i++) begin
            i_led_sink_host.write_reg(`ADDR_GENERAL,
                                      {2'h0, i[3], 2'h0, i[2:0]});
            expFlags[3] = i[0];
            expFlags[2] = i[3] ? 1'h0 : (i[2] ? i[0] : i[1]);
            expFlags[1] = i[3];
            expFlags[0] = i[0] | i[1] | i[3];
            @(negedge mclk);
            check_flags({primarySinkEnable, secondarySinkEnable,
                feedbackMode, analogEnable}, expFlags);
            read_check(`ADDR_GENERAL, {2'h3, i[3], 2'h0, i[2:0]});
        end
        // ramp rates, upper bits ignored, table points
        i_led_sink_host.write_reg(`ADDR_GENERAL, 8'h01);
        ramp(`ADDR_PRIMARY, 8'hE3, PF, 1'h0, 5'h00, 5'h03,
             17'h003E8);
        i_led_sink_host.write_reg(`ADDR_GENERAL, 8'h11);
        ramp(`ADDR_PRIMARY, 8'h10, P1, 1'h0, 5'h03, 5'h10,
             17'h0222E);
        i_led_sink_host.write_reg(`ADDR_GENERAL, 8'h09);
        ramp(`ADDR_PRIMARY, 8'h1E, P2, 1'h0, 5'h10, 5'h1E,
             17'h155CC);
        i_led_sink_host.write_reg(`ADDR_GENERAL, 8'h19);
        ramp(`ADDR_PRIMARY, 8'h01, P3, 1'h0, 5'h1E, 5'h01,
             17'h0007D);
        i_led_sink_host.write_reg(`ADDR_GENERAL, 8'h13);
        ramp(`ADDR_SECONDARY, 8'h3F, P1, 1'h1, 5'h00, 5'h1F,
             17'h186A0);
        // shared mode: secondary follows the primary brightness
        ramp(`ADDR_GENERAL, 8'h17, P1, 1'h1, 5'h1F, 5'h01,
             17'h0007D);
        read_check(`ADDR_PRIMARY, 8'h01);
        read_check(`ADDR_SECONDARY, 8'h3F);
        read_check(`ADDR_GENERAL, 8'hD7);
        complete_run();
    end
endmodule
